// File: src/acp_consts.svh
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH

// Register byte offsets on the bus.
`define ACP_OFF_CTRL      12'h000
`define ACP_OFF_PIN_LOW   12'h004
`define ACP_OFF_PIN_MID   12'h008
`define ACP_OFF_PIN_TOP   12'h00c
`define ACP_OFF_STAT      12'h010
`define ACP_ADDR_W        12

// Control register fields.
`define ACP_CTRL_SEL_LSB  0
`define ACP_CTRL_DIV_LSB  2
`define ACP_CTRL_MODE_LSB 4
`define ACP_CTRL_HWT_BIT  6
`define ACP_CTRL_CONT_BIT 7
`define ACP_CTRL_SWS_BIT  8

// Status register fields.
`define ACP_STAT_BUSY_BIT 0
`define ACP_STAT_CONT_BIT 1
`define ACP_STAT_DONE_BIT 2
`define ACP_STAT_IGN_BIT  3

// Clock select codes.
`define ACP_SEL_BUS       2'h0
`define ACP_SEL_BUS2      2'h1
`define ACP_SEL_ALT       2'h2
`define ACP_SEL_ASYNC     2'h3

// Resolution codes.
`define ACP_MODE_8        2'h0
`define ACP_MODE_12       2'h1
`define ACP_MODE_10       2'h2

// Converter clock ticks per conversion, by resolution.
`define ACP_CYC_8         5'h08
`define ACP_CYC_10        5'h0a
`define ACP_CYC_12        5'h0c

// Reset values and misc.
`define ACP_RST_PINS      8'h00
`define ACP_PIN_GRP_W     8
`define ACP_ASYNC_HALF    4'h2
`define ACP_AHB_NONSEQ    1

`endif

// File: src/acp_pkg.sv
`include "acp_consts.svh"

package acp_pkg;

  typedef enum logic [1:0] {
    ACP_CLK_BUS   = `ACP_SEL_BUS,
    ACP_CLK_BUS2  = `ACP_SEL_BUS2,
    ACP_CLK_ALT   = `ACP_SEL_ALT,
    ACP_CLK_ASYNC = `ACP_SEL_ASYNC
  } acp_clksel_t;

  typedef enum logic {
    ACP_IDLE,
    ACP_CONV
  } acp_conv_state_t;

endpackage : acp_pkg

// File: src/acp_clk_if.sv
`timescale 1ns/1ns

interface acp_clk_if;
  acp_pkg::acp_clksel_t sel;
  logic [1:0]           divide;
  logic                 low_power;
  logic                 tick;

  modport ctl (output sel, output divide, output low_power, input tick);
  modport gen (input sel, input divide, input low_power, output tick);
endinterface : acp_clk_if

// File: src/acp_clkgen.sv
`timescale 1ns/1ns
`include "acp_consts.svh"

module acp_clkgen #(
  parameter logic [3:0] ASYNC_HALF = `ACP_ASYNC_HALF
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Alternate clock pin.
  input wire logic alternate_clock,
  // Selection and tick.
  acp_clk_if.gen   cif
);

  // Elaboration check: a zero half period would wrap the internal oscillator to one pulse every 16 bus clocks.
  if (ASYNC_HALF == 4'h0) begin : g_bad_half
    $error("acp_clkgen: ASYNC_HALF must be nonzero");
  end

  typedef struct packed {
    logic       alt_s1;
    logic       alt_s2;
    logic       alt_s3;
    logic       half;
    logic [3:0] osc_cnt;
    logic [2:0] div_cnt;
    logic       tick;
  } acp_cg_t;

  acp_cg_t r_reg;
  acp_cg_t r_next;
  logic    src;
  logic [2:0] mask;

  // Source pick, low-power gating and the 1/2/4/8 divider.
  always_comb begin
    r_next        = r_reg;
    r_next.alt_s1 = alternate_clock;
    r_next.alt_s2 = r_reg.alt_s1;
    r_next.alt_s3 = r_reg.alt_s2;
    r_next.half   = ~r_reg.half;
    // The internal oscillator is free-running so it survives low-power states.
    r_next.osc_cnt = (r_reg.osc_cnt == 4'h0) ? ASYNC_HALF - 4'h1 : r_reg.osc_cnt - 4'h1;
    case (cif.sel)
      acp_pkg::ACP_CLK_BUS:  src = 1'b1;
      acp_pkg::ACP_CLK_BUS2: src = r_reg.half;
      acp_pkg::ACP_CLK_ALT:  src = r_reg.alt_s2 & ~r_reg.alt_s3;
      default:               src = (r_reg.osc_cnt == 4'h0);
    endcase
    // Only the internal oscillator keeps running in wait or stop3.
    if (cif.low_power && cif.sel != acp_pkg::ACP_CLK_ASYNC) begin // RULE7
      src = 1'b0;
    end
    mask = 3'((4'h1 << cif.divide) - 4'h1); // RULE8
    r_next.tick = src && ((r_reg.div_cnt & mask) == mask);
    if (src) begin
      r_next.div_cnt = r_reg.div_cnt + 3'h1;
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cif.tick = r_reg.tick;

endmodule : acp_clkgen

// File: src/acp_ctrl.sv
`timescale 1ns/1ns
`include "acp_consts.svh"

// Behaviour
// RULE1 - Mid register bits disable pins 8 to 15.
// RULE2 - Top register holds channels 16 to 23.
// RULE3 - Disabled pin output buffer forced off.
// RULE4 - Disabled pin input reads as zero.
// RULE5 - Disabled pin pullup forced off.
// RULE6 - Four clock sources, bus clock at reset.
// RULE7 - Internal clock keeps running in low power.
// RULE8 - Source divided by 1, 2, 4 or 8.
// RULE9 - Enabled hardware trigger rising edge starts conversion.
// RULE10 - Edges during a conversion are ignored.
// RULE11 - Continuous mode: only first edge counts.
// RULE12 - Hardware trigger works with every mode.
// RULE13 - Mode selects 12, 10 or 8 bits.
// RULE14 - Start by software or hardware trigger.
// RULE15 - Select codes: bus, bus/2, alternate, internal.
// RULE16 - Low register covers channels 0 to 7.
module acp_ctrl #(
  parameter int         NCH        = 24,
  parameter logic [3:0] ASYNC_HALF = `ACP_ASYNC_HALF
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins from outside.
  input  wire logic        hw_trigger_input,
  input  wire logic        alternate_clock,
  input  wire logic        low_power_req,
  input  wire logic [23:0] pin_in,
  // Port logic requests.
  input  wire logic [23:0] port_dir_out,
  input  wire logic [23:0] port_pullup_req,
  // Pad controls and port read data.
  output logic      [23:0] pad_out_en,
  output logic      [23:0] pad_pullup_en,
  output logic      [23:0] port_read_data,
  // Converter side.
  output logic             conv_start,
  output logic             conv_busy,
  output logic      [1:0]  conv_resolution,
  output logic             converter_input_clock
);

  // Elaboration checks: the pad gating and the register map serve exactly 24 channels.
  if (NCH != 24) begin : g_bad_nch
    $error("acp_ctrl: NCH must be 24");
  end
  // A zero half period would wrap the internal oscillator count to one pulse every 16 bus clocks.
  if (ASYNC_HALF == 4'h0) begin : g_bad_half
    $error("acp_ctrl: ASYNC_HALF must be nonzero");
  end

  // Software sees each register as one aligned word, and every access completes
  // with no wait states and an OKAY answer.
  // The control word at the base holds the clock select, the divide, the resolution,
  // the trigger enable and the continuous flag, plus a start bit that reads as zero.
  // Three pin disable words follow for channels 0 to 7, 8 to 15 and 16 to 23; only their
  // low byte is stored and the rest reads as zero.
  // The status word shows busy and continuous activity and two sticky flags, done and
  // ignored edge, which software clears by writing ones.
  // Unmapped offsets read zero and drop writes, so a stray access cannot upset the pads.
  // Pad controls leave flip-flops one edge after the port requests change; that extra
  // edge keeps the pad enables glitch free, at the price of one clock of latency.
  // Pin levels take three edges to reach the port read data, and a trigger pin edge
  // takes three edges to reach the sequencer, because both pass two synchronising stages.

  // All state of the block except the clock generator's, registered as one word.
  typedef struct packed {
    logic                         wr_pend;
    logic [`ACP_ADDR_W-1:0]       addr_q;
    logic [31:0]                  hrdata;
    logic                         hreadyout;
    logic                         hresp;
    acp_pkg::acp_clksel_t         sel;
    logic [1:0]                   divide;
    logic [1:0]                   mode;
    logic                         hwt_en;
    logic                         cont;
    logic [23:0]                  pin_dis;
    acp_pkg::acp_conv_state_t     state;
    logic [4:0]                   cnt;
    logic [1:0]                   res;
    logic                         cont_act;
    logic                         done;
    logic                         ign;
    logic                         start;
    logic                         cclk;
    logic                         trg_s1;
    logic                         trg_s2;
    logic                         trg_s3;
    logic                         lp_s1;
    logic                         lp_s2;
    logic [23:0]                  pin_s1;
    logic [23:0]                  pin_s2;
    logic [23:0]                  oe;
    logic [23:0]                  pu;
    logic [23:0]                  rd;
  } acp_st_t;

  acp_st_t r_reg;
  acp_st_t r_next;

  // Clock source pick and divider live in their own module behind an interface.
  acp_clk_if cif ();

  acp_clkgen #(
    .ASYNC_HALF (ASYNC_HALF)
  ) u_clkgen (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .alternate_clock (alternate_clock),
    .cif             (cif)
  );

  // Drive the clock generator from the stored fields and the synchronised low-power request.
  assign cif.sel       = r_reg.sel;
  assign cif.divide    = r_reg.divide;
  assign cif.low_power = r_reg.lp_s2;

  // Per-channel pad gating: a set disable bit overrides the port settings.
  // Pullups also drop while a pin drives, since a pullup on an output only wastes current.
  logic [23:0] oe_g;
  logic [23:0] pu_g;
  logic [23:0] rd_g;
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi++) begin : g_pin
      assign oe_g[gi] = port_dir_out[gi] & ~r_reg.pin_dis[gi];    // RULE3
      assign rd_g[gi] = r_reg.pin_s2[gi] & ~r_reg.pin_dis[gi];    // RULE4
      assign pu_g[gi] = port_pullup_req[gi] & ~r_reg.pin_dis[gi] & ~port_dir_out[gi]; // RULE5
    end
  endgenerate

  // Conversion length for a resolution code.
  // The unused mode code runs with the 8-bit length rather than hanging the sequencer.
  function automatic logic [4:0] acp_len(input logic [1:0] m);
    logic [4:0] l;
    l = `ACP_CYC_8;
    if (m == `ACP_MODE_12) l = `ACP_CYC_12;
    else if (m == `ACP_MODE_10) l = `ACP_CYC_10;
    return l;
  endfunction : acp_len

  // Scratch values of the combinational process; each is set on every pass.
  logic        wr;
  logic        rise;
  logic        sw_go;
  logic        go;
  logic [31:0] rv;
  logic [`ACP_ADDR_W-1:0] ra;

  // Bus slave, register writes, trigger filtering and conversion sequencing.
  always_comb begin
    r_next           = r_reg;
    r_next.hreadyout = 1'b1;
    r_next.hresp     = 1'b0;
    r_next.start     = 1'b0;
    r_next.cclk      = cif.tick;
    r_next.trg_s1    = hw_trigger_input;
    r_next.trg_s2    = r_reg.trg_s1;
    r_next.trg_s3    = r_reg.trg_s2;
    r_next.lp_s1     = low_power_req;
    r_next.lp_s2     = r_reg.lp_s1;
    r_next.pin_s1    = pin_in;
    r_next.pin_s2    = r_reg.pin_s1;
    r_next.oe        = oe_g;
    r_next.pu        = pu_g;
    r_next.rd        = rd_g;
    // The edge is found on synchronised copies only, so the raw trigger pin never
    // feeds logic that could see it change in mid cycle.
    rise  = r_reg.trg_s2 & ~r_reg.trg_s3;
    sw_go = 1'b0;
    wr    = r_reg.wr_pend;
    // Data phase of a write lands here; zero wait states.
    // Writes use the address captured a cycle earlier, as the bus splits address and data.
    if (wr && r_reg.addr_q == `ACP_OFF_CTRL) begin
      r_next.sel    = acp_pkg::acp_clksel_t'(hwdata[`ACP_CTRL_SEL_LSB +: 2]); // RULE6 RULE15
      r_next.divide = hwdata[`ACP_CTRL_DIV_LSB +: 2];  // RULE8
      r_next.mode   = hwdata[`ACP_CTRL_MODE_LSB +: 2]; // RULE13
      r_next.hwt_en = hwdata[`ACP_CTRL_HWT_BIT];
      r_next.cont   = hwdata[`ACP_CTRL_CONT_BIT];
      // Software start is honoured only while hardware triggering is off.
      sw_go = hwdata[`ACP_CTRL_SWS_BIT] & ~r_reg.hwt_en; // RULE14
    end else if (wr && r_reg.addr_q == `ACP_OFF_PIN_LOW) begin
      r_next.pin_dis[7:0] = hwdata[`ACP_PIN_GRP_W-1:0];   // RULE16
    end else if (wr && r_reg.addr_q == `ACP_OFF_PIN_MID) begin
      r_next.pin_dis[15:8] = hwdata[`ACP_PIN_GRP_W-1:0];  // RULE1
    end else if (wr && r_reg.addr_q == `ACP_OFF_PIN_TOP) begin
      r_next.pin_dis[23:16] = hwdata[`ACP_PIN_GRP_W-1:0]; // RULE2
    end else if (wr && r_reg.addr_q == `ACP_OFF_STAT) begin
      // Write one to clear; a same-cycle set below still wins.
      if (hwdata[`ACP_STAT_DONE_BIT]) r_next.done = 1'b0;
      if (hwdata[`ACP_STAT_IGN_BIT]) r_next.ign = 1'b0;
    end
    go = sw_go | (r_reg.hwt_en & rise); // RULE9 RULE14
    // A hardware edge while busy is only flagged; software that must see every edge
    // has to poll the ignored flag, since nothing is queued.
    case (r_reg.state)
      acp_pkg::ACP_IDLE: begin
        if (go) begin
          // Resolution and continuous mode are latched per conversion.
          r_next.state    = acp_pkg::ACP_CONV;
          r_next.cnt      = acp_len(r_next.mode); // RULE12 RULE13
          r_next.res      = r_next.mode;
          r_next.cont_act = r_next.cont;
          r_next.start    = 1'b1;
        end
      end
      default: begin
        // Edges while busy are dropped, not queued; this covers continuous runs too.
        // The count is loaded at start, so a mode write mid conversion only affects the next.
        if (r_reg.hwt_en && rise) begin // RULE10 RULE11
          r_next.ign = 1'b1;
        end
        if (cif.tick) begin
          if (r_reg.cnt == 5'h01) begin
            r_next.done = 1'b1;
            if (r_reg.cont_act && r_reg.cont) begin
              r_next.cnt   = acp_len(r_reg.mode);
              r_next.res   = r_reg.mode;
              r_next.start = 1'b1;
            end else begin
              r_next.state    = acp_pkg::ACP_IDLE;
              r_next.cont_act = 1'b0;
            end
          end else begin
            r_next.cnt = r_reg.cnt - 5'h01;
          end
        end
      end
    endcase
    // Nothing here waits on the converter, so the ready answer can stay high at all times.
    // Address phase: capture, and prepare read data from post-write values.
    ra = haddr[`ACP_ADDR_W-1:0];
    r_next.wr_pend = hsel & hready & htrans[`ACP_AHB_NONSEQ] & hwrite;
    r_next.addr_q  = ra;
    rv = 32'h0000_0000;
    if (ra == `ACP_OFF_CTRL) begin
      rv[`ACP_CTRL_SEL_LSB +: 2]  = r_next.sel;
      rv[`ACP_CTRL_DIV_LSB +: 2]  = r_next.divide;
      rv[`ACP_CTRL_MODE_LSB +: 2] = r_next.mode;
      rv[`ACP_CTRL_HWT_BIT]       = r_next.hwt_en;
      rv[`ACP_CTRL_CONT_BIT]      = r_next.cont;
    end else if (ra == `ACP_OFF_PIN_LOW) begin
      rv[`ACP_PIN_GRP_W-1:0] = r_next.pin_dis[7:0];
    end else if (ra == `ACP_OFF_PIN_MID) begin
      rv[`ACP_PIN_GRP_W-1:0] = r_next.pin_dis[15:8];
    end else if (ra == `ACP_OFF_PIN_TOP) begin
      rv[`ACP_PIN_GRP_W-1:0] = r_next.pin_dis[23:16];
    end else if (ra == `ACP_OFF_STAT) begin
      rv[`ACP_STAT_BUSY_BIT] = (r_next.state == acp_pkg::ACP_CONV);
      rv[`ACP_STAT_CONT_BIT] = r_next.cont_act;
      rv[`ACP_STAT_DONE_BIT] = r_next.done;
      rv[`ACP_STAT_IGN_BIT]  = r_next.ign;
    end
    if (hsel && hready && htrans[`ACP_AHB_NONSEQ] && !hwrite) begin
      r_next.hrdata = rv;
    end
  end

  // State register; reset picks the bus clock and clears every disable bit.
  // Reset values are constants only; the sticky flags and the sequencer start idle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg           <= '0;
      r_reg.sel       <= acp_pkg::ACP_CLK_BUS; // RULE6
      r_reg.state     <= acp_pkg::ACP_IDLE;
      r_reg.pin_dis   <= {3{`ACP_RST_PINS}};   // RULE16
      r_reg.hreadyout <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs come straight from the state register.
  // The busy output decodes a one-bit state flop, so it cannot glitch.
  assign hrdata                = r_reg.hrdata;
  assign hreadyout             = r_reg.hreadyout;
  assign hresp                 = r_reg.hresp;
  assign pad_out_en            = r_reg.oe;
  assign pad_pullup_en         = r_reg.pu;
  assign port_read_data        = r_reg.rd;
  assign conv_start            = r_reg.start;
  assign conv_busy             = (r_reg.state == acp_pkg::ACP_CONV);
  assign conv_resolution       = r_reg.res;
  assign converter_input_clock = r_reg.cclk;

  // hsize is accepted but only whole-word transfers are supported.
  // Upper address bits are ignored, so the map repeats every 4 KB of address space.
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:`ACP_ADDR_W]};

endmodule : acp_ctrl

// File: verif/acp_ctrl_assertions.sv
`timescale 1ns/1ns

module acp_ctrl_chk (
  // Clock and reset.
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus answer.
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Port side.
  input wire logic [23:0] port_dir_out,
  input wire logic [23:0] port_pullup_req,
  input wire logic [23:0] pin_in,
  input wire logic [23:0] pad_out_en,
  input wire logic [23:0] pad_pullup_en,
  input wire logic [23:0] port_read_data,
  // Converter side.
  input wire logic        conv_start,
  input wire logic        conv_busy,
  input wire logic [1:0]  conv_resolution,
  input wire logic        converter_input_clock
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [4:0] tick_cnt;

  // Ticks of the running conversion; a restart clears it so continuous runs stay bounded.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_cnt <= 5'h00;
    else if (conv_start) tick_cnt <= 5'h00;
    else if (conv_busy && converter_input_clock) tick_cnt <= tick_cnt + 5'h01;
  end

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  drive_off_a: assert property ((pad_out_en & ~$past(port_dir_out)) == 24'h000000)
    else $error("pad driven without port request");
  pull_off_a: assert property ((pad_pullup_en & ($past(port_dir_out) | ~$past(port_pullup_req))) == 24'h000000)
    else $error("pullup on without request");
  read_zero_a: assert property ((port_read_data & ~$past(pin_in, 3)) == 24'h000000)
    else $error("port read shows a level the pin lacks");
  read_gate_a: assert property ((port_read_data & $past(port_dir_out) & ~pad_out_en) == 24'h000000)
    else $error("disabled pin reads other than zero");
  start_busy_a: assert property (conv_start |-> conv_busy)
    else $error("start without busy");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  busy_cause_a: assert property ($rose(conv_busy) |-> conv_start)
    else $error("busy rose without a start");
  res_hold_a: assert property (conv_busy && !conv_start |=> $stable(conv_resolution))
    else $error("resolution changed mid conversion");
  conv_len_a: assert property (tick_cnt <= 5'h0b)
    else $error("conversion ran past twelve ticks");
endmodule : acp_ctrl_chk

bind acp_ctrl acp_ctrl_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .port_dir_out, .port_pullup_req,
  .pin_in, .pad_out_en, .pad_pullup_en, .port_read_data, .conv_start, .conv_busy, .conv_resolution,
  .converter_input_clock);

// File: verif/acp_far_model.sv
`timescale 1ns/1ns

module acp_far_model #(
  parameter int ALT_NS = 312
) (
  // Pacing clock.
  input wire logic        hclk,
  // Far side pins.
  output logic            hw_trigger_input,
  output logic            alternate_clock,
  output logic     [23:0] pin_in
);
  initial begin
    hw_trigger_input = 1'b0;
    pin_in = 24'h000000;
  end

  // Free running alternate source, unrelated in phase to the bus clock.
  // Its half period never lands on a rising bus clock edge, so sampling it is free of races.
  always begin
    alternate_clock = 1'b0;
    forever #(ALT_NS / 2) alternate_clock = ~alternate_clock;
  end

  // One trigger pulse, held long enough that the synchroniser cannot miss it.
  task automatic fire;
    @(posedge hclk);
    hw_trigger_input <= 1'b1;
    repeat (2) @(posedge hclk);
    hw_trigger_input <= 1'b0;
  endtask : fire

  // New analog pad levels.
  task automatic drive_pins(input logic [23:0] v);
    @(posedge hclk);
    pin_in <= v;
  endtask : drive_pins
endmodule : acp_far_model

// File: verif/testbench.sv
`timescale 1ns/1ns
`include "acp_consts.svh"

module testbench;
  // Bus master and port side stimulus.
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        low_power_req = 1'b0;
  logic [23:0] port_dir_out = 24'h0;
  logic [23:0] port_pullup_req = 24'h0;
  // Design outputs and far side pins.
  logic [31:0] hrdata;
  logic        hreadyout, hresp, hw_trigger_input, alternate_clock;
  logic [23:0] pin_in, pad_out_en, pad_pullup_en, port_read_data;
  logic        conv_start, conv_busy, converter_input_clock;
  logic [1:0]  conv_resolution;
  logic [31:0] rv;
  int          num_errors = 0;
  int          checks_done = 0;
  int          ns, nb, nt;
  logic [1:0]  mc [3] = '{2'h0, 2'h2, 2'h1};
  int          ml [3] = '{8, 10, 12};

  always #50 hclk = ~hclk;

  acp_ctrl #(.NCH(24), .ASYNC_HALF(4'h2)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .hw_trigger_input,
    .alternate_clock, .low_power_req, .pin_in, .port_dir_out, .port_pullup_req, .pad_out_en,
    .pad_pullup_en, .port_read_data, .conv_start, .conv_busy, .conv_resolution, .converter_input_clock);

  acp_far_model far (.hclk, .hw_trigger_input, .alternate_clock, .pin_in);

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rng(input string nm, input int v, input int lo, input int hi);
    chk(nm, 32'(v >= lo && v <= hi), 32'h1);
  endtask : rng

  // Bounded wait for ready; a hang ends the run with a mismatch.
  task automatic wait_rdy;
    for (int i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    num_errors++;
    $display("[FAIL] bus ready expected 1 seen timeout");
    print_verdict();
  endtask : wait_rdy

  // One single word transfer; read data is taken at the end of the data phase.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask : xfer

  // Counts starts, busy ticks and ticks, sampled mid-cycle where outputs are settled.
  task automatic run(input int n);
    ns = 0;
    nb = 0;
    nt = 0;
    repeat (n) begin
      @(negedge hclk);
      ns += int'(conv_start === 1'b1);
      nb += int'(conv_busy === 1'b1 && converter_input_clock === 1'b1);
      nt += int'(converter_input_clock === 1'b1);
    end
    @(posedge hclk);
  endtask : run

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 12'(4 * i), 32'h0);
      chk("reset value", rv, 32'h0);
    end
    run(64);
    rng("reset clock ticks", nt, 63, 65);
    $display("test reset done");
    port_dir_out <= 24'hffffff;
    port_pullup_req <= 24'hffffff;
    far.drive_pins(24'hffffff);
    xfer(1'b1, `ACP_OFF_PIN_LOW, 32'ha5);
    xfer(1'b1, `ACP_OFF_PIN_MID, 32'h3c);
    xfer(1'b1, `ACP_OFF_PIN_TOP, 32'hc3);
    xfer(1'b0, `ACP_OFF_PIN_MID, 32'h0);
    chk("mid readback", rv, 32'h3c);
    xfer(1'b0, 12'h020, 32'h0);
    chk("unmapped read", rv, 32'h0);
    run(4);
    chk("out enable", 32'(pad_out_en), 32'h3cc35a);
    port_dir_out <= 24'h0;
    run(5);
    chk("pullup", 32'(pad_pullup_en), 32'h3cc35a);
    chk("port read", 32'(port_read_data), 32'h3cc35a);
    $display("test pins done");
    for (int s = 0; s < 2; s++) begin
      for (int d = 0; d < 4; d++) begin
        xfer(1'b1, `ACP_OFF_CTRL, 32'(s | (d << 2)));
        run(8);
        run(64);
        rng("divided ticks", nt, (64 >> (s + d)) - 1, (64 >> (s + d)) + 1);
      end
    end
    xfer(1'b1, `ACP_OFF_CTRL, 32'h2);
    run(8);
    run(64);
    rng("alternate ticks", nt, 20, 22);
    xfer(1'b1, `ACP_OFF_CTRL, 32'h3);
    low_power_req <= 1'b1;
    run(8);
    run(64);
    rng("internal ticks in low power", nt, 31, 33);
    xfer(1'b1, `ACP_OFF_CTRL, 32'h0);
    run(8);
    run(64);
    chk("bus ticks in low power", 32'(nt), 32'h0);
    low_power_req <= 1'b0;
    $display("test clocks done");
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, `ACP_OFF_CTRL, 32'h100 | (32'(mc[i]) << 4));
      run(20);
      chk("soft starts", 32'(ns), 32'h1);
      rng("conversion ticks", nb, ml[i] - 1, ml[i] + 1);
      chk("resolution", 32'(conv_resolution), 32'(mc[i]));
    end
    $display("test modes done");
    xfer(1'b1, `ACP_OFF_CTRL, 32'h50);
    xfer(1'b1, `ACP_OFF_STAT, 32'hc);
    far.fire();
    run(6);
    chk("trigger start", 32'(ns), 32'h1);
    far.fire();
    run(20);
    chk("busy edge starts", 32'(ns), 32'h0);
    xfer(1'b0, `ACP_OFF_STAT, 32'h0);
    chk("ignored flag", 32'(rv[3]), 32'h1);
    xfer(1'b1, `ACP_OFF_CTRL, 32'h150);
    run(20);
    chk("soft start with trigger on", 32'(ns), 32'h0);
    $display("test single trigger done");
    xfer(1'b1, `ACP_OFF_CTRL, 32'he0);
    xfer(1'b1, `ACP_OFF_STAT, 32'hc);
    far.fire();
    run(40);
    rng("continuous starts", ns, 3, 4);
    far.fire();
    run(4);
    xfer(1'b0, `ACP_OFF_STAT, 32'h0);
    chk("continuous and ignored", rv & 32'ha, 32'ha);
    $display("test continuous trigger done");
    print_verdict();
  end
endmodule : testbench
